/* bench/fpe_checker.sv */
`timescale 1ns/10ps
module fpe_checker
(
	input wire logic	clk_sys,
	input wire logic	nrst,
	input wire logic	regWr,
	input wire logic	arrWr,
	input wire logic [7:0]	protectStartBits,
	input wire logic	testLevelVoltage,
	input wire logic	highVoltageEnable,
	input wire logic	eraseGo,
	input wire logic	massGo,
	input wire logic	programGo,
	input wire logic [15:0]	targetAddr,
	input wire logic	byteProgPulse,
	input wire fpe_pkg::fpe_wr_t	byteProg
);
	import fpe_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	chk_sel_excl: assert property (!(eraseGo && programGo))
		else $error("both selects");
	chk_go_hv: assert property (eraseGo || programGo |-> highVoltageEnable)
		else $error("go without hv");
	chk_hv_req: assert property ($rose(highVoltageEnable) |-> $past(regWr))
		else $error("hv unrequested");
	chk_mass_open: assert property ($rose(massGo) |-> $past(protectStartBits) == PROT_OPEN)
		else $error("mass while protected");
	chk_prot_range: assert property ($rose(highVoltageEnable) && !testLevelVoltage |->
		protectStartBits == PROT_OPEN || targetAddr < {2'b11, protectStartBits, 6'h00})
		else $error("hv on protected");
	chk_page_align: assert property ($rose(eraseGo) && !massGo |->
		targetAddr[5:0] == 6'h00 || targetAddr == VEC_LO)
		else $error("page base");
	chk_row_match: assert property (byteProgPulse |-> byteProg.addr[15:5] == targetAddr[15:5])
		else $error("row mismatch");
	chk_pulse_cause: assert property (byteProgPulse |-> $past(arrWr && programGo))
		else $error("pulse uncaused");
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import fpe_pkg::*;
	logic clk_sys, nrst, regWr, regRd, arrWr, arrProtRd, testLevelVoltage, e;
	logic highVoltageEnable, eraseGo, massGo, programGo, byteProgPulse;
	logic [7:0] regAddr, regWdata, regRdata, protectStartBits, d, p;
	logic [15:0] targetAddr, a;
	fpe_wr_t arrReq, byteProg;
	int n_mismatch, comparisons;
	logic [32:0] rows [8] = '{{8'hFF, 8'h01, 16'hC020, 1'b1}, {8'h00, 8'h01, 16'hC020, 1'b0},
		{8'h04, 8'h02, 16'hC0C0, 1'b1}, {8'h04, 8'h02, 16'hC100, 1'b0},
		{8'hFF, 8'h06, 16'hC000, 1'b1}, {8'hFE, 8'h06, 16'hC000, 1'b0},
		{8'hFD, 8'h02, 16'hFF40, 1'b0}, {8'hFF, 8'h03, 16'hC000, 1'b0}};
	fpe_ctrl i_dut (.clk_sys, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .arrWr,
		.arrReq, .arrProtRd, .protectStartBits, .testLevelVoltage, .highVoltageEnable,
		.eraseGo, .massGo, .programGo, .targetAddr, .byteProgPulse, .byteProg);
	initial
	begin
		clk_sys = 0;
		forever #5 clk_sys = !clk_sys;
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] wd);
		@(posedge clk_sys);
		regAddr <= ad;
		regWdata <= wd;
		regWr <= w;
		regRd <= !w;
		@(posedge clk_sys);
		{regWr, regRd} <= 2'b00;
		#1 d = regRdata;
	endtask
	task automatic arr(input logic w, input logic [15:0] ad);
		@(posedge clk_sys);
		arrReq <= {ad, 8'h5A};
		arrWr <= w;
		arrProtRd <= !w;
		@(posedge clk_sys);
		{arrWr, arrProtRd} <= 2'b00;
		#1;
	endtask
	task automatic run(input logic [7:0] c, input logic [15:0] ad);
		bus(1, CTRL_ADDR, c);
		arr(0, ad);
		arr(1, ad);
		bus(1, CTRL_ADDR, c | 8'h08);
		bus(0, CTRL_ADDR, 8'h00);
	endtask
	task automatic tally_and_finish;
		$display("n_mismatch %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		{nrst, regWr, regRd, arrWr, arrProtRd, testLevelVoltage, regAddr, regWdata, arrReq} = '0;
		protectStartBits = 8'hFF;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		bus(0, CTRL_ADDR, 8'h00);
		chk(d, 8'h00);
		foreach (rows[i])
		begin
			@(posedge clk_sys);
			{p, d, a, e} = rows[i];
			protectStartBits <= p;
			run(d, a);
			chk(d[3], e);
			bus(1, CTRL_ADDR, 8'h00);
		end
		run(8'h01, 16'hC020);
		arr(1, 16'hC025);
		chk({byteProgPulse, byteProg.addr}, {1'b1, 16'hC025});
		arr(1, 16'hC045);
		chk(byteProgPulse, 1'b0);
		bus(1, CTRL_ADDR, 8'h00);
		bus(0, 8'h3C, 8'h00);
		chk(d, 8'h00);
		protectStartBits <= 8'h00;
		testLevelVoltage <= 1'b1;
		run(8'h02, 16'hC040);
		chk(d[3], 1'b1);
		tally_and_finish();
	end
endmodule
bind fpe_ctrl fpe_checker i_chk (.clk_sys, .nrst, .regWr, .arrWr, .protectStartBits,
	.testLevelVoltage, .highVoltageEnable, .eraseGo, .massGo, .programGo, .targetAddr,
	.byteProgPulse, .byteProg);

/* hdl/fpe_ctrl.sv */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module fpe_ctrl
(
	input  wire logic           clk_sys,
	input  wire logic           nrst,
	input  wire logic [7:0]     regAddr,
	input  wire logic [7:0]     regWdata,
	input  wire logic           regWr,
	input  wire logic           regRd,
	output logic      [7:0]     regRdata,
	input  wire logic           arrWr,
	input  wire fpe_pkg::fpe_wr_t arrReq,
	input  wire logic           arrProtRd,
	input  wire logic [7:0]     protectStartBits,
	input  wire logic           testLevelVoltage,
	output logic                highVoltageEnable,
	output logic                eraseGo,
	output logic                massGo,
	output logic                programGo,
	output logic [15:0]         targetAddr,
	output logic                byteProgPulse,
	output fpe_pkg::fpe_wr_t    byteProg
);
	import fpe_pkg::*;

	logic [3:0]  ctrl_ff, nxt_ctrl;
	logic        latched_ff, nxt_latched;
	logic        protRd_ff, nxt_protRd;
	logic [15:0] tgt_ff, nxt_tgt;
	logic [7:0]  rdata_ff, nxt_rdata;
	logic        bp_ff, nxt_bp;
	fpe_wr_t     bw_ff, nxt_bw;
	logic        tv1_ff, tv2_ff;
	logic        ersGo_ff, nxt_ersGo;
	logic        massGo_ff, nxt_massGo;
	logic        pgmGo_ff, nxt_pgmGo;
	logic [15:0] protStart;
	logic        tgtProt, inArray, hvOk;
	logic        program_select, ers;

	assign protStart = {2'b11, protectStartBits, 6'h00};
	assign inArray = arrReq.addr >= ARRAY_LO;
	assign program_select = ctrl_ff[BIT_PGM];
	assign ers = ctrl_ff[BIT_ERASE];

	always_comb
	begin
		tgtProt = 1'b0;
		if (!tv2_ff)
		begin
			if (protectStartBits == 8'h00)
				tgtProt = 1'b1;
			else if (protectStartBits != PROT_OPEN && tgt_ff >= protStart)
				tgtProt = 1'b1;
			if (protectStartBits != PROT_OPEN && protectStartBits != PROT_VEC
				&& tgt_ff[15:6] == PROT_ADDR[15:6])
				tgtProt = 1'b1;
			if (ctrl_ff[BIT_MASS] && ers && protectStartBits != PROT_OPEN)
				tgtProt = 1'b1;
		end
		hvOk = (program_select ^ ers) && latched_ff && protRd_ff && !tgtProt;
	end

	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		nxt_latched = latched_ff;
		nxt_protRd = protRd_ff;
		nxt_tgt = tgt_ff;
		nxt_rdata = 8'h00;
		nxt_bp = 1'b0;
		nxt_bw = bw_ff;
		if (regWr && regAddr == CTRL_ADDR)
		begin
			nxt_ctrl[BIT_MASS] = regWdata[BIT_MASS];
			if (regWdata[BIT_PGM] && regWdata[BIT_ERASE])
			begin
				nxt_ctrl[BIT_PGM] = program_select;
				nxt_ctrl[BIT_ERASE] = ers;
			end
			else
			begin
				nxt_ctrl[BIT_PGM] = regWdata[BIT_PGM] && !ers;
				nxt_ctrl[BIT_ERASE] = regWdata[BIT_ERASE] && !program_select;
			end
			if (!regWdata[BIT_HV])
				nxt_ctrl[BIT_HV] = 1'b0;
			else if (!ctrl_ff[BIT_HV])
				nxt_ctrl[BIT_HV] = hvOk;
			if (!nxt_ctrl[BIT_PGM] && !nxt_ctrl[BIT_ERASE])
			begin
				nxt_latched = 1'b0;
				nxt_protRd = 1'b0;
			end
		end
		if (arrProtRd && (program_select || ers) && !ctrl_ff[BIT_HV])
			nxt_protRd = 1'b1;
		if (arrWr && inArray && (program_select || ers))
		begin
			if (!ctrl_ff[BIT_HV] && protRd_ff)
			begin
				nxt_latched = 1'b1;
				if (ers)
					nxt_tgt = arrReq.addr[15:0] >= VEC_LO ? VEC_LO
						: {arrReq.addr[15:6], 6'h00};
				else
					nxt_tgt = {arrReq.addr[15:5], 5'h00};
			end
			else if (ctrl_ff[BIT_HV] && program_select && arrReq.addr[15:5] == tgt_ff[15:5])
			begin
				nxt_bp = 1'b1;
				nxt_bw = arrReq;
			end
		end
		// Go levels follow the next control value so they stay aligned with the enable bit.
		nxt_ersGo = nxt_ctrl[BIT_HV] & nxt_ctrl[BIT_ERASE];
		nxt_massGo = nxt_ctrl[BIT_HV] & nxt_ctrl[BIT_ERASE] & nxt_ctrl[BIT_MASS];
		nxt_pgmGo = nxt_ctrl[BIT_HV] & nxt_ctrl[BIT_PGM];
		if (regRd && regAddr == CTRL_ADDR)
			nxt_rdata = {4'h0, ctrl_ff};
		else if (regRd && regAddr == STAT_ADDR)
			nxt_rdata = {5'h00, tgtProt, protRd_ff, latched_ff};
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_ff <= CTRL_RESET;
			latched_ff <= 1'b0;
			protRd_ff <= 1'b0;
			tgt_ff <= 16'h0000;
			rdata_ff <= 8'h00;
			bp_ff <= 1'b0;
			bw_ff <= '0;
			tv1_ff <= 1'b0;
			tv2_ff <= 1'b0;
			ersGo_ff <= 1'b0;
			massGo_ff <= 1'b0;
			pgmGo_ff <= 1'b0;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			latched_ff <= nxt_latched;
			protRd_ff <= nxt_protRd;
			tgt_ff <= nxt_tgt;
			rdata_ff <= nxt_rdata;
			bp_ff <= nxt_bp;
			bw_ff <= nxt_bw;
			tv1_ff <= testLevelVoltage;
			tv2_ff <= tv1_ff;
			ersGo_ff <= nxt_ersGo;
			massGo_ff <= nxt_massGo;
			pgmGo_ff <= nxt_pgmGo;
		end
	end

	// Erase outputs drive the array; a covered unprotected protect byte clears too.
	assign regRdata = rdata_ff;
	assign highVoltageEnable = ctrl_ff[BIT_HV];
	assign eraseGo = ersGo_ff;
	assign massGo = massGo_ff;
	assign programGo = pgmGo_ff;
	assign targetAddr = tgt_ff;
	assign byteProgPulse = bp_ff;
	assign byteProg = bw_ff;
endmodule

/* hdl/fpe_pkg.sv */
package fpe_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h08;
	localparam logic [7:0] STAT_ADDR = 8'h0C;
	localparam int BIT_PGM = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_MASS = 2;
	localparam int BIT_HV = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [15:0] ARRAY_LO = 16'hC000;
	localparam logic [15:0] PROT_ADDR = 16'hFF7E;
	localparam logic [15:0] VEC_LO = 16'hFFDC;
	localparam logic [7:0] PROT_OPEN = 8'hFF;
	localparam logic [7:0] PROT_VEC = 8'hFE;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0]  data;
	} fpe_wr_t;
endpackage
